// file: drsl_sequencer.sv
// Purpose: Drives the network, device and port link LEDs of a motor drive from firmware state over APB.
// Assumes: APB slave with zero wait states; inputs are synchronous to mclk.
// Notes: Pattern counters run freely, so a pattern may start mid-period when its cause appears.
// Contract
// - Network green off in init, blink preop, single flash safeop, on op, flicker bootstrap.
// - Network red stays off while no communication error is reported.
// - Watchdog timeout shows double flash on network red.
// - Internal error leaving communication state shows single flash on network red.
// - Configuration error makes network red blink continuously.
// - Blink is a continuous square wave near 2.5 Hz.
// - Flicker is a continuous square wave near 10 Hz.
// - Each network flash lights about 0.2 s; the flash group is followed by 1 s dark.
// - Power stage disabled states: device green blinks slowly, device red off.
// - Slow blink toggles continuously near 1 Hz.
// - Operation enabled or quick stop: device green on, device red off.
// - Fault: device green off, device red on.
// - Fault reaction active: both device LEDs on.
// - Invalid firmware or download: red on, green flashes 0.9 s off, 0.1 s on.
// - Each fieldbus port drives its own link LED from its own state.
// - Link LED flickers when port open with frame activity.
`timescale 1ns/1ps
`default_nettype none

// Free-running pattern counter that advances once per tick and wraps at PERIOD.
module drsl_cycle
  import drsl_pkg::*;
#(
  parameter int unsigned PERIOD = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  output logic [CNT_W-1:0] cnt
);

  drsl_cyc_t st_r;
  drsl_cyc_t st_nxt;

  // Advance on the tick and wrap so the pattern repeats without a gap.
  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      if (st_r.cnt == CNT_W'(PERIOD - 1)) begin
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  // Cleared by reset so every timebase starts from a known phase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt = st_r.cnt;

  a_cycle_wrap: assert property (@(posedge mclk) disable iff (rst)
    (tick && st_r.cnt == CNT_W'(PERIOD - 1)) |=> (st_r.cnt == '0))
    else $error("Pattern counter did not wrap at its period.");

endmodule : drsl_cycle

module drsl_sequencer
  import drsl_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC,
  parameter int unsigned BLINK_TK = BLINK_T,
  parameter int unsigned FLICK_TK = FLICK_T,
  parameter int unsigned SLOW_TK = SLOW_T,
  parameter int unsigned FLASH_TK = FLASH_T,
  parameter int unsigned PAUSE_TK = PAUSE_T,
  parameter int unsigned FW_ON_TK = FW_ON_T,
  parameter int unsigned FW_OFF_TK = FW_OFF_T,
  parameter int unsigned ACT_HOLD_TK = ACT_HOLD_T
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] port_frame,
  output drsl_leds_t leds
);

  drsl_state_t st_r;
  drsl_state_t st_nxt;
  logic [CNT_W-1:0] blink_cnt;
  logic [CNT_W-1:0] flick_cnt;
  logic [CNT_W-1:0] slow_cnt;
  logic [CNT_W-1:0] sgl_cnt;
  logic [CNT_W-1:0] dbl_cnt;
  logic [CNT_W-1:0] fw_cnt;
  logic blink_on;
  logic flick_on;
  logic slow_on;
  logic sgl_on;
  logic dbl_on;
  logic fw_on;
  logic unmapped;
  logic wr_en;
  logic setup;

  // Pattern timebases, all driven by the shared tick.
  drsl_cycle #(.PERIOD(2 * BLINK_TK)) u_blink (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(blink_cnt));
  drsl_cycle #(.PERIOD(2 * FLICK_TK)) u_flick (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(flick_cnt));
  drsl_cycle #(.PERIOD(2 * SLOW_TK)) u_slow (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(slow_cnt));
  drsl_cycle #(.PERIOD(FLASH_TK + PAUSE_TK)) u_sgl (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(sgl_cnt));
  drsl_cycle #(.PERIOD(3 * FLASH_TK + PAUSE_TK)) u_dbl (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(dbl_cnt));
  drsl_cycle #(.PERIOD(FW_ON_TK + FW_OFF_TK)) u_fw (.mclk(mclk), .rst(rst), .tick(st_r.tick), .cnt(fw_cnt));

  // Wave shapes decoded from the counters.
  assign blink_on = blink_cnt < CNT_W'(BLINK_TK);
  assign flick_on = flick_cnt < CNT_W'(FLICK_TK);
  assign slow_on = slow_cnt < CNT_W'(SLOW_TK);
  assign sgl_on = sgl_cnt < CNT_W'(FLASH_TK);
  // Second flash starts after a gap as long as one flash.
  assign dbl_on = (dbl_cnt < CNT_W'(FLASH_TK)) ||
                  ((dbl_cnt >= CNT_W'(2 * FLASH_TK)) && (dbl_cnt < CNT_W'(3 * FLASH_TK)));
  assign fw_on = fw_cnt < CNT_W'(FW_ON_TK);

  // APB decode; the slave never inserts wait states.
  assign setup = psel && !penable;
  assign unmapped = (paddr != OFF_NET_CTRL) && (paddr != OFF_DEV_CTRL) &&
                    (paddr != OFF_PORT_CTRL) && (paddr != OFF_LED_STAT);
  assign wr_en = psel && penable && pwrite && !unmapped;
  assign pready = psel && penable;
  assign pslverr = psel && penable && unmapped;
  assign prdata = st_r.prdata;
  assign leds = st_r.leds;

  // Next state: tick divider, register writes, activity stretch and LED selection.
  always_comb begin
    st_nxt = st_r;
    // Tick divider.
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == CNT_W'(TICK_DIV - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + CNT_W'(1);
    end
    // Register writes.
    if (wr_en) begin
      unique case (paddr)
        OFF_NET_CTRL: begin
          st_nxt.net_st = pwdata[NET_ST_LSB +: 3];
          st_nxt.wdog_err = pwdata[NET_WDOG_BIT];
          st_nxt.int_err = pwdata[NET_INT_BIT];
          st_nxt.cfg_err = pwdata[NET_CFG_BIT];
        end
        OFF_DEV_CTRL: begin
          st_nxt.dev_st = pwdata[DEV_ST_LSB +: 3];
          st_nxt.fw_bad = pwdata[DEV_FW_BIT];
        end
        OFF_PORT_CTRL: begin
          st_nxt.port_open = pwdata[PORT_OPEN_LSB +: 2];
        end
        default: begin
          st_nxt.port_open = st_r.port_open;
        end
      endcase
    end
    // Read data is latched in the setup cycle so it comes from a flip-flop in the access cycle.
    if (setup) begin
      st_nxt.prdata = '0;
      unique case (paddr)
        OFF_NET_CTRL: begin
          st_nxt.prdata[NET_ST_LSB +: 3] = st_r.net_st;
          st_nxt.prdata[NET_WDOG_BIT] = st_r.wdog_err;
          st_nxt.prdata[NET_INT_BIT] = st_r.int_err;
          st_nxt.prdata[NET_CFG_BIT] = st_r.cfg_err;
        end
        OFF_DEV_CTRL: begin
          st_nxt.prdata[DEV_ST_LSB +: 3] = st_r.dev_st;
          st_nxt.prdata[DEV_FW_BIT] = st_r.fw_bad;
        end
        OFF_PORT_CTRL: begin
          st_nxt.prdata[PORT_OPEN_LSB +: 2] = st_r.port_open;
        end
        OFF_LED_STAT: begin
          st_nxt.prdata[5:0] = st_r.leds;
          st_nxt.prdata[6] = st_r.act_cnt[0] != '0;
          st_nxt.prdata[7] = st_r.act_cnt[1] != '0;
        end
        default: begin
          st_nxt.prdata = '0;
        end
      endcase
    end
    // A frame reloads the stretch timer, so brief traffic still shows as visible flicker.
    for (int i = 0; i < 2; i++) begin
      if (port_frame[i]) begin
        st_nxt.act_cnt[i] = CNT_W'(ACT_HOLD_TK);
      end else if (st_r.tick && st_r.act_cnt[i] != '0) begin
        st_nxt.act_cnt[i] = st_r.act_cnt[i] - CNT_W'(1);
      end
      if (!st_r.port_open[i]) begin
        st_nxt.leds.link[i] = 1'b0;
      end else if (st_r.act_cnt[i] != '0) begin
        st_nxt.leds.link[i] = flick_on;
      end else begin
        st_nxt.leds.link[i] = 1'b1;
      end
    end
    // Network green follows the communication state.
    unique case (st_r.net_st)
      NS_PREOP: st_nxt.leds.net_green = blink_on;
      NS_SAFEOP: st_nxt.leds.net_green = sgl_on;
      NS_OP: st_nxt.leds.net_green = 1'b1;
      NS_BOOT: st_nxt.leds.net_green = flick_on;
      default: st_nxt.leds.net_green = 1'b0;
    endcase
    // Network red shows the most severe active error.
    if (st_r.wdog_err) begin
      st_nxt.leds.net_red = dbl_on;
    end else if (st_r.int_err) begin
      st_nxt.leds.net_red = sgl_on;
    end else if (st_r.cfg_err) begin
      st_nxt.leds.net_red = blink_on;
    end else begin
      st_nxt.leds.net_red = 1'b0;
    end
    // Device LEDs; a missing firmware image overrides the power stage display.
    if (st_r.fw_bad) begin
      st_nxt.leds.dev_green = fw_on;
      st_nxt.leds.dev_red = 1'b1;
    end else begin
      unique case (st_r.dev_st)
        DS_SW_ON_DIS, DS_READY, DS_SWITCHED_ON: begin
          st_nxt.leds.dev_green = slow_on;
          st_nxt.leds.dev_red = 1'b0;
        end
        DS_OP_EN, DS_QSTOP: begin
          st_nxt.leds.dev_green = 1'b1;
          st_nxt.leds.dev_red = 1'b0;
        end
        DS_FAULT: begin
          st_nxt.leds.dev_green = 1'b0;
          st_nxt.leds.dev_red = 1'b1;
        end
        DS_FAULT_REACT: begin
          st_nxt.leds.dev_green = 1'b1;
          st_nxt.leds.dev_red = 1'b1;
        end
        default: begin
          st_nxt.leds.dev_green = 1'b0;
          st_nxt.leds.dev_red = 1'b0;
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.net_st <= NET_ST_RST;
      st_r.dev_st <= DEV_ST_RST;
      st_r.fw_bad <= FW_BAD_RST;
      st_r.port_open <= PORT_OPEN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // A link with fresh traffic on an open port.
  sequence s_open_busy0;
    st_r.port_open[0] && (st_r.act_cnt[0] != '0);
  endsequence

  // A frame arriving on an open port.
  sequence s_frame_open1;
    port_frame[1] && st_r.port_open[1];
  endsequence

  a_net_green_init: assert property (@(posedge mclk) disable iff (rst)
    (st_r.net_st == NS_INIT) |=> !leds.net_green)
    else $error("Network green lit in init state.");

  a_net_red_quiet: assert property (@(posedge mclk) disable iff (rst)
    !(st_r.wdog_err || st_r.int_err || st_r.cfg_err) |=> !leds.net_red)
    else $error("Network red lit without an error.");

  a_wdog_double: assert property (@(posedge mclk) disable iff (rst)
    st_r.wdog_err |=> (leds.net_red == $past(dbl_on)))
    else $error("Watchdog error not shown as double flash.");

  a_int_single: assert property (@(posedge mclk) disable iff (rst)
    (!st_r.wdog_err && st_r.int_err) |=> (leds.net_red == $past(sgl_on)))
    else $error("Internal error not shown as single flash.");

  a_cfg_blink: assert property (@(posedge mclk) disable iff (rst)
    (!st_r.wdog_err && !st_r.int_err && st_r.cfg_err) |=> (leds.net_red == $past(blink_on)))
    else $error("Configuration error not shown as blink.");

  a_blink_edge: assert property (@(posedge mclk) disable iff (rst)
    $changed(blink_on) |-> $past(st_r.tick))
    else $error("Blink wave changed without a tick.");

  a_dbl_gap: assert property (@(posedge mclk) disable iff (rst)
    (st_r.wdog_err && dbl_cnt == CNT_W'(FLASH_TK)) |=> !leds.net_red)
    else $error("Double flash has no gap between flashes.");

  a_dev_fault: assert property (@(posedge mclk) disable iff (rst)
    (!st_r.fw_bad && st_r.dev_st == DS_FAULT) |=> (!leds.dev_green && leds.dev_red))
    else $error("Fault state not shown on device LEDs.");

  a_dev_react: assert property (@(posedge mclk) disable iff (rst)
    (!st_r.fw_bad && st_r.dev_st == DS_FAULT_REACT) |=> (leds.dev_green && leds.dev_red))
    else $error("Fault reaction not shown with both device LEDs.");

  a_fw_flash: assert property (@(posedge mclk) disable iff (rst)
    st_r.fw_bad |=> (leds.dev_red && leds.dev_green == $past(fw_on)))
    else $error("Firmware state not shown on device LEDs.");

  a_link_closed: assert property (@(posedge mclk) disable iff (rst)
    !st_r.port_open[1] |=> !leds.link[1])
    else $error("Link LED lit on a closed port.");

  a_link_flicker: assert property (@(posedge mclk) disable iff (rst)
    s_open_busy0 |=> (leds.link[0] == $past(flick_on)))
    else $error("Busy open port does not flicker.");

  a_frame_stretch: assert property (@(posedge mclk) disable iff (rst)
    s_frame_open1 ##1 st_r.port_open[1] |=> (leds.link[1] == $past(flick_on)))
    else $error("Frame did not start link flicker.");

  a_tick_gap: assert property (@(posedge mclk) disable iff (rst)
    st_r.tick |=> !st_r.tick)
    else $error("Tick pulses back to back.");

endmodule : drsl_sequencer
`default_nettype wire

// file: drsl_pkg.sv
// Purpose: Shared constants, register layout and carrier types of the drive status LED sequencer.
// Assumes: A 10 MHz system clock; all pattern timing runs off a 100 us tick.
// Notes: Pattern times are kept in milliseconds and converted to ticks here.
`default_nettype none
package drsl_pkg;

  // System clock and the tick that every pattern counter advances on.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned CNT_W = 16;

  // Pattern times in milliseconds, as the indicator behaviour defines them.
  localparam int unsigned BLINK_HALF_MS = 200;   // 2.5 Hz square wave.
  localparam int unsigned FLICK_HALF_MS = 50;    // 10 Hz square wave.
  localparam int unsigned SLOW_HALF_MS = 500;    // 1 Hz square wave.
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_PAUSE_MS = 1000;
  localparam int unsigned FW_ON_MS = 100;
  localparam int unsigned FW_OFF_MS = 900;
  localparam int unsigned ACT_HOLD_MS = 100;

  // The same times counted in ticks.
  localparam int unsigned BLINK_T = BLINK_HALF_MS * 1000 / TICK_US;
  localparam int unsigned FLICK_T = FLICK_HALF_MS * 1000 / TICK_US;
  localparam int unsigned SLOW_T = SLOW_HALF_MS * 1000 / TICK_US;
  localparam int unsigned FLASH_T = FLASH_ON_MS * 1000 / TICK_US;
  localparam int unsigned PAUSE_T = FLASH_PAUSE_MS * 1000 / TICK_US;
  localparam int unsigned FW_ON_T = FW_ON_MS * 1000 / TICK_US;
  localparam int unsigned FW_OFF_T = FW_OFF_MS * 1000 / TICK_US;
  localparam int unsigned ACT_HOLD_T = ACT_HOLD_MS * 1000 / TICK_US;

  // Register byte offsets.
  localparam logic [7:0] OFF_NET_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEV_CTRL = 8'h04;
  localparam logic [7:0] OFF_PORT_CTRL = 8'h08;
  localparam logic [7:0] OFF_LED_STAT = 8'h0c;

  // Field positions.
  localparam int unsigned NET_ST_LSB = 0;
  localparam int unsigned NET_WDOG_BIT = 8;
  localparam int unsigned NET_INT_BIT = 9;
  localparam int unsigned NET_CFG_BIT = 10;
  localparam int unsigned DEV_ST_LSB = 0;
  localparam int unsigned DEV_FW_BIT = 8;
  localparam int unsigned PORT_OPEN_LSB = 0;

  // Communication state codes.
  localparam logic [2:0] NS_INIT = 3'h0;
  localparam logic [2:0] NS_PREOP = 3'h1;
  localparam logic [2:0] NS_SAFEOP = 3'h2;
  localparam logic [2:0] NS_OP = 3'h3;
  localparam logic [2:0] NS_BOOT = 3'h4;

  // Power stage state codes.
  localparam logic [2:0] DS_SW_ON_DIS = 3'h0;
  localparam logic [2:0] DS_READY = 3'h1;
  localparam logic [2:0] DS_SWITCHED_ON = 3'h2;
  localparam logic [2:0] DS_OP_EN = 3'h3;
  localparam logic [2:0] DS_QSTOP = 3'h4;
  localparam logic [2:0] DS_FAULT = 3'h5;
  localparam logic [2:0] DS_FAULT_REACT = 3'h6;

  // Reset values of the control fields.
  localparam logic [2:0] NET_ST_RST = NS_INIT;
  localparam logic [2:0] DEV_ST_RST = DS_SW_ON_DIS;
  localparam logic FW_BAD_RST = 1'b0;
  localparam logic [1:0] PORT_OPEN_RST = 2'h0;

  // LED drive lines.
  typedef struct packed {
    logic net_green;
    logic net_red;
    logic dev_green;
    logic dev_red;
    logic [1:0] link;
  } drsl_leds_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [CNT_W-1:0] tick_cnt;
    logic tick;
    logic [2:0] net_st;
    logic wdog_err;
    logic int_err;
    logic cfg_err;
    logic [2:0] dev_st;
    logic fw_bad;
    logic [1:0] port_open;
    logic [1:0][CNT_W-1:0] act_cnt;
    logic [31:0] prdata;
    drsl_leds_t leds;
  } drsl_state_t;

  // State of one pattern counter.
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } drsl_cyc_t;

endpackage : drsl_pkg
`default_nettype wire

// file: drsl_led_watch.sv
// Purpose: Operator-side model of the six status LEDs; counts lit samples and turn-on edges per LED.
// Assumes: LEDs are active high and change only just after a rising edge of mclk.
// Notes: A sample that is neither 0 nor 1 adds a large penalty, so an unknown never looks like a pattern.
`timescale 1ns/1ps
`default_nettype none

module drsl_led_watch
  import drsl_pkg::*;
(
  input wire logic mclk,
  input wire logic clr,
  input wire drsl_leds_t leds,
  output int lit_cnt [6],
  output int rise_cnt [6]
);
  logic [5:0] prev_r;

  // The clearing sample is the first of the window, so a window of one period sees every edge once.
  always_ff @(posedge mclk) begin
    for (int b = 0; b < 6; b++) begin
      lit_cnt[b] <= (clr ? 0 : lit_cnt[b]) + (leds[b] === 1'b1 ? 1 : (leds[b] === 1'b0 ? 0 : 1000));
      rise_cnt[b] <= (clr ? 0 : rise_cnt[b]) + ((leds[b] === 1'b1 && prev_r[b] !== 1'b1) ? 1 : 0);
    end
    prev_r <= leds;
  end
endmodule : drsl_led_watch

`default_nettype wire

// file: drsl_sequencer_test.sv
// Purpose: Self-checking bench for the status LED sequencer, driving registers over APB.
// Assumes: Shortened pattern counts; every window below is one full period of the pattern watched.
// Notes: Lit time and turn-on count over a whole period do not depend on the pattern's phase.
`timescale 1ns/1ps
`default_nettype none

module drsl_sequencer_test;
  import drsl_pkg::*;
  localparam int DIV = 4;
  localparam int BL = 4, FL = 2, SL = 6, FS = 3, PS = 8, FWN = 2, FWF = 5, ACT = 3;
  localparam int W_BL = 2 * BL * DIV, W_FL = 2 * FL * DIV, W_SL = 2 * SL * DIV;
  localparam int W_SF = (FS + PS) * DIV, W_DF = (3 * FS + PS) * DIV, W_FW = (FWN + FWF) * DIV;
  localparam int B_NG = 5, B_NR = 4, B_DG = 3, B_DR = 2, B_L1 = 1, B_L0 = 0;

  logic mclk, rst, psel, penable, pwrite, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, ev;
  logic [1:0] port_frame;
  drsl_leds_t leds;
  int lit_cnt [6];
  int rise_cnt [6];
  int n_fail = 0;
  int checks_done = 0;

  drsl_sequencer #(.TICK_DIV(DIV), .BLINK_TK(BL), .FLICK_TK(FL), .SLOW_TK(SL), .FLASH_TK(FS),
    .PAUSE_TK(PS), .FW_ON_TK(FWN), .FW_OFF_TK(FWF), .ACT_HOLD_TK(ACT)) drsl_sequencer_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_frame(port_frame),
    .leds(leds));

  drsl_led_watch drsl_led_watch_inst (.mclk(mclk), .clr(clr), .leds(leds), .lit_cnt(lit_cnt),
    .rise_cnt(rise_cnt));

  // A 10 MHz clock.
  always #50 mclk = ~mclk;

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      $display("Error at %0t: no pready", $time);
      print_verdict;
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Transfer and compare read data (reads only) and the error response.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
    apb(wr, a, d);
    checks_done++;
    if (ev !== err || (!wr && rv !== exp)) begin
      n_fail++;
      $display("Error at %0t: addr %h data %h err %b", $time, a, rv, ev);
    end
  endtask : xfer

  // Let a write reach the LEDs, then watch one window of win samples.
  task measure(input int win);
    repeat (3) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (win - 1) @(posedge mclk);
    @(negedge mclk);
  endtask : measure

  task chk(input int bit_no, input int lit, input int rises);
    checks_done++;
    if (lit_cnt[bit_no] != lit || rise_cnt[bit_no] != rises) begin
      n_fail++;
      $display("Error at %0t: led %0d lit %0d rises %0d, want %0d %0d", $time, bit_no,
        lit_cnt[bit_no], rise_cnt[bit_no], lit, rises);
    end
  endtask : chk

  // A hang anywhere ends the run through the same report.
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    $display("Error at %0t: run timed out", $time);
    print_verdict;
  end

  // Tables: communication states, error combinations and power states with their expected patterns.
  int st_win [5] = '{W_BL, W_SF, W_SF, W_FL, W_FL};
  int st_lit [5] = '{BL * DIV, FS * DIV, W_SF, FL * DIV, 0};
  int st_rs [5] = '{1, 1, 0, 1, 0};
  logic [31:0] er_val [5] = '{32'h403, 32'h203, 32'h103, 32'h703, 32'h603};
  int er_win [5] = '{W_BL, W_SF, W_DF, W_DF, W_SF};
  int er_lit [5] = '{BL * DIV, FS * DIV, 2 * FS * DIV, 2 * FS * DIV, FS * DIV};
  int er_rs [5] = '{1, 1, 2, 2, 1};
  int dg_lit [8] = '{SL * DIV, SL * DIV, SL * DIV, W_SL, W_SL, 0, W_SL, 0};
  int dg_rs [8] = '{1, 1, 1, 0, 0, 0, 0, 0};
  int dr_lit [8] = '{0, 0, 0, 0, 0, W_SL, W_SL, 0};

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_frame = 2'h0;
    clr = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // Reset values of the control registers, and the patterns of the reset state.
    xfer(1'b0, OFF_NET_CTRL, 32'h0, 32'h0, 1'b0);
    xfer(1'b0, OFF_DEV_CTRL, 32'h0, 32'h0, 1'b0);
    xfer(1'b0, OFF_PORT_CTRL, 32'h0, 32'h0, 1'b0);
    measure(W_SL);
    chk(B_NG, 0, 0);
    chk(B_NR, 0, 0);
    chk(B_DG, SL * DIV, 1);
    chk(B_DR, 0, 0);
    chk(B_L0, 0, 0);
    // Each communication state after init in turn, then an unused code that must leave green dark.
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, OFF_NET_CTRL, 32'(i + 1), 32'h0, 1'b0);
      measure(st_win[i]);
      chk(B_NG, st_lit[i], st_rs[i]);
      chk(B_NR, 0, 0);
    end
    // Error classes alone and together, with green steadily on in operational.
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, OFF_NET_CTRL, er_val[i], 32'h0, 1'b0);
      measure(er_win[i]);
      chk(B_NR, er_lit[i], er_rs[i]);
      chk(B_NG, er_win[i], 0);
    end
    xfer(1'b0, OFF_NET_CTRL, 32'h0, 32'h603, 1'b0);
    xfer(1'b1, OFF_NET_CTRL, 32'h3, 32'h0, 1'b0);
    // Every power state, and the unused code that turns both device LEDs off.
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, OFF_DEV_CTRL, 32'(i), 32'h0, 1'b0);
      measure(W_SL);
      chk(B_DG, dg_lit[i], dg_rs[i]);
      chk(B_DR, dr_lit[i], 0);
    end
    // Invalid firmware overrides an enabled power stage.
    xfer(1'b1, OFF_DEV_CTRL, 32'h103, 32'h0, 1'b0);
    measure(W_FW);
    chk(B_DG, FWN * DIV, 1);
    chk(B_DR, W_FW, 0);
    // Steady state readback, a write to the read-only word and an unmapped address.
    xfer(1'b1, OFF_DEV_CTRL, 32'h5, 32'h0, 1'b0);
    repeat (3) @(posedge mclk);
    xfer(1'b0, OFF_LED_STAT, 32'h0, 32'h24, 1'b0);
    xfer(1'b1, OFF_LED_STAT, 32'hff, 32'h0, 1'b0);
    xfer(1'b1, 8'h10, 32'h7, 32'h0, 1'b1);
    xfer(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, OFF_NET_CTRL, 32'h0, 32'h3, 1'b0);
    // Port 0 open and idle, port 1 closed but seeing frames.
    port_frame <= 2'h2;
    xfer(1'b1, OFF_PORT_CTRL, 32'h1, 32'h0, 1'b0);
    measure(W_FL);
    chk(B_L0, W_FL, 0);
    chk(B_L1, 0, 0);
    xfer(1'b0, OFF_LED_STAT, 32'h0, 32'ha5, 1'b0);
    // Both open, traffic on port 0 only once port 1's activity has run out.
    port_frame <= 2'h1;
    xfer(1'b1, OFF_PORT_CTRL, 32'h3, 32'h0, 1'b0);
    repeat (24) @(posedge mclk);
    measure(W_FL);
    chk(B_L0, FL * DIV, 1);
    chk(B_L1, W_FL, 0);
    // Traffic stops; the link LED returns to steady on after the activity hold.
    @(posedge mclk);
    port_frame <= 2'h0;
    repeat (24) @(posedge mclk);
    measure(W_FL);
    chk(B_L0, W_FL, 0);
    // Traffic on the open outbound port alone makes only its own link LED flicker.
    @(posedge mclk);
    port_frame <= 2'h2;
    measure(W_FL);
    chk(B_L1, FL * DIV, 1);
    chk(B_L0, W_FL, 0);
    print_verdict;
  end
endmodule : drsl_sequencer_test

`default_nettype wire
